// ==== logic/amcs_sequencer.sv ====
`timescale 1ns/1ns
`include "amcs_cfg.svh"

module amcs_sequencer #(
  parameter int NUM_CH = `AMCS_NUM_CH,
  parameter int NUM_BITS = `AMCS_NUM_BITS,
  parameter int SAMPLE_CLKS = `AMCS_SAMPLE_CLKS
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Channel address and its latch strobe
  input wire logic [2:0] chan_addr_i,
  input wire logic addr_latch_i,
  // Conversion start
  input wire logic start_i,
  // Threshold detector, high when summing node is above trip point
  input wire logic cmp_trip_i,
  // Analog switch controls
  output logic [NUM_CH-1:0] chan_sel_o,
  output logic sample_o,
  output logic [NUM_BITS-1:0] weight_upper_o,
  // Result latch and conversion done
  output logic [NUM_BITS-1:0] result_o,
  output logic done_o
);

  localparam int EOC_MAX = `AMCS_EOC_MAX_CLKS;
  localparam int IW = $clog2(NUM_BITS);
  localparam int CW = $clog2(SAMPLE_CLKS);
  localparam logic [CW-1:0] SAMP_LAST = CW'(SAMPLE_CLKS - 1);
  localparam logic [IW-1:0] IDX_MSB = IW'(NUM_BITS - 1);
  localparam logic [IW-1:0] IDX_ONE = IW'(1);
  localparam logic [NUM_BITS-1:0] W_MSB = {1'b1, {(NUM_BITS-1){1'b0}}};

  amcs_pkg::amcs_state_t st_r;
  logic [2:0] addr_r;
  logic ale_d_r;
  logic start_d_r;
  logic [CW-1:0] samp_cnt_r;
  logic [IW-1:0] idx_r;
  logic [NUM_BITS-1:0] bdr_r;
  logic [NUM_BITS-1:0] bdr_nxt;
  logic [NUM_BITS-1:0] weight_nxt;
  logic ale_rise;
  logic start_rise;

  // Edge detection; inputs are already synchronous to the clock
  assign ale_rise = addr_latch_i & ~ale_d_r;
  assign start_rise = start_i & ~start_d_r;

  // Previous strobe levels
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ale_d_r <= 1'b0;
      start_d_r <= 1'b0;
    end else begin
      ale_d_r <= addr_latch_i;
      start_d_r <= start_i;
    end
  end

  // Channel code latch and one-hot mux select
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      addr_r <= 3'h0;
      chan_sel_o <= NUM_CH'(`AMCS_CHSEL_RST);
    end else if (ale_rise) begin
      addr_r <= chan_addr_i;
      chan_sel_o <= NUM_CH'(1) << chan_addr_i;
    end
  end

  // Phase sequencing; a start edge always wins, aborting any conversion
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r <= amcs_pkg::AMCS_ST_IDLE;
      samp_cnt_r <= '0;
      idx_r <= IDX_MSB;
    end else if (start_rise) begin
      st_r <= amcs_pkg::AMCS_ST_SAMPLE;
      samp_cnt_r <= '0;
      idx_r <= IDX_MSB;
    end else begin
      case (st_r)
        amcs_pkg::AMCS_ST_IDLE: begin
          st_r <= amcs_pkg::AMCS_ST_IDLE;
        end
        amcs_pkg::AMCS_ST_SAMPLE: begin
          samp_cnt_r <= samp_cnt_r + CW'(1);
          if (samp_cnt_r == SAMP_LAST) begin
            st_r <= amcs_pkg::AMCS_ST_DECIDE;
            idx_r <= IDX_MSB;
          end
        end
        amcs_pkg::AMCS_ST_DECIDE: begin
          if (idx_r == '0) begin
            st_r <= amcs_pkg::AMCS_ST_LATCH;
          end else begin
            idx_r <= idx_r - IDX_ONE;
          end
        end
        amcs_pkg::AMCS_ST_LATCH: begin
          // Back to tracking the input until the next start
          st_r <= amcs_pkg::AMCS_ST_IDLE;
        end
        default: begin
          st_r <= amcs_pkg::AMCS_ST_IDLE;
        end
      endcase
    end
  end

  // Next decision bits and weight switching for one step
  always_comb begin
    bdr_nxt = bdr_r;
    weight_nxt = weight_upper_o;
    if (st_r == amcs_pkg::AMCS_ST_DECIDE) begin
      if (cmp_trip_i) begin
        bdr_nxt[idx_r] = 1'b1;
        weight_nxt[idx_r] = 1'b0;
      end
      if (idx_r != '0) begin
        weight_nxt[idx_r - IDX_ONE] = 1'b1;
      end
    end
  end

  // Bit decision register; straight binary, no inversion
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bdr_r <= '0;
    end else if (start_rise) begin
      bdr_r <= '0;
    end else begin
      bdr_r <= bdr_nxt;
    end
  end

  // Capacitor weights: all low while sampling, MSB alone at first step
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      weight_upper_o <= '0;
    end else if (start_rise) begin
      weight_upper_o <= '0;
    end else if (st_r == amcs_pkg::AMCS_ST_SAMPLE && samp_cnt_r == SAMP_LAST) begin
      weight_upper_o <= W_MSB;
    end else if (st_r == amcs_pkg::AMCS_ST_LATCH) begin
      weight_upper_o <= '0;
    end else begin
      weight_upper_o <= weight_nxt;
    end
  end

  // Sampling switch: closed except during bit decisions and the latch step
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sample_o <= 1'b1;
    end else if (start_rise) begin
      sample_o <= 1'b1;
    end else if (st_r == amcs_pkg::AMCS_ST_SAMPLE && samp_cnt_r == SAMP_LAST) begin
      sample_o <= 1'b0;
    end else if (st_r == amcs_pkg::AMCS_ST_LATCH) begin
      sample_o <= 1'b1;
    end
  end

  // Output latch and done flag; done drops on the start edge itself
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      result_o <= NUM_BITS'(`AMCS_RESULT_RST);
      done_o <= 1'b0;
    end else if (start_rise) begin
      result_o <= NUM_BITS'(`AMCS_RESULT_RST);
      done_o <= 1'b0;
    end else if (st_r == amcs_pkg::AMCS_ST_LATCH) begin
      result_o <= bdr_r;
      done_o <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_chan_load;
    ale_rise |=> chan_sel_o == (NUM_CH'(1) << $past(chan_addr_i)) && $onehot(chan_sel_o);
  endproperty
  a_chan_load: assert property (p_chan_load) else $error("channel select wrong after strobe");

  property p_chan_hold;
    !ale_rise |=> $stable(chan_sel_o) && $stable(addr_r);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel changed without strobe");

  property p_start_clear;
    start_rise |=> result_o == `AMCS_RESULT_RST && !done_o;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("result not cleared on start");

  property p_sample_len;
    st_r == amcs_pkg::AMCS_ST_DECIDE && $past(st_r) == amcs_pkg::AMCS_ST_SAMPLE
      |-> $past(samp_cnt_r) == SAMP_LAST && $past(sample_o) && !sample_o;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sampling length wrong");

  property p_restart;
    start_rise && st_r != amcs_pkg::AMCS_ST_IDLE
      |=> st_r == amcs_pkg::AMCS_ST_SAMPLE && samp_cnt_r == '0 && bdr_r == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("conversion not restarted");

  property p_eoc_delay;
    start_rise |-> ##[1:EOC_MAX] !done_o;
  endproperty
  a_eoc_delay: assert property (p_eoc_delay) else $error("done did not drop in time");

  property p_msb_first;
    st_r == amcs_pkg::AMCS_ST_DECIDE && $past(st_r) == amcs_pkg::AMCS_ST_SAMPLE
      |-> weight_upper_o == W_MSB && idx_r == IDX_MSB;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first step not MSB alone");

  property p_trip;
    st_r == amcs_pkg::AMCS_ST_DECIDE && !start_rise
      |=> bdr_r[$past(idx_r)] == $past(cmp_trip_i)
        && weight_upper_o[$past(idx_r)] == !$past(cmp_trip_i);
  endproperty
  a_trip: assert property (p_trip) else $error("bit or weight wrong after decision");

  property p_descend;
    st_r == amcs_pkg::AMCS_ST_DECIDE && idx_r != '0 && !start_rise
      |=> idx_r == $past(idx_r) - IDX_ONE && weight_upper_o[idx_r];
  endproperty
  a_descend: assert property (p_descend) else $error("weights not descending");

  property p_finish;
    st_r == amcs_pkg::AMCS_ST_DECIDE && idx_r == '0 && !start_rise
      |=> st_r == amcs_pkg::AMCS_ST_LATCH ##1 (st_r == amcs_pkg::AMCS_ST_IDLE || st_r == amcs_pkg::AMCS_ST_SAMPLE);
  endproperty
  a_finish: assert property (p_finish) else $error("sequence did not finish");

  property p_binary;
    st_r == amcs_pkg::AMCS_ST_LATCH && !start_rise |=> result_o == $past(bdr_r);
  endproperty
  a_binary: assert property (p_binary) else $error("latched result differs");

  property p_done_busy;
    st_r != amcs_pkg::AMCS_ST_IDLE |-> !done_o;
  endproperty
  a_done_busy: assert property (p_done_busy) else $error("done high mid conversion");

  // Phase invariants; a broken phase shows here before the result goes bad
  property p_one_hot;
    $onehot(chan_sel_o);
  endproperty
  a_one_hot: assert property (p_one_hot) else $error("channel select not one hot");

  property p_start_sample;
    start_rise |=> st_r == amcs_pkg::AMCS_ST_SAMPLE && sample_o && weight_upper_o == '0;
  endproperty
  a_start_sample: assert property (p_start_sample) else $error("sampling not begun on start");

  property p_sample_hold;
    st_r == amcs_pkg::AMCS_ST_SAMPLE |-> sample_o && weight_upper_o == '0;
  endproperty
  a_sample_hold: assert property (p_sample_hold) else $error("switches wrong while sampling");

  property p_idx_sample;
    st_r == amcs_pkg::AMCS_ST_SAMPLE |-> idx_r == IDX_MSB;
  endproperty
  a_idx_sample: assert property (p_idx_sample) else $error("decision index not at top");

  property p_bits_clear;
    st_r == amcs_pkg::AMCS_ST_SAMPLE |-> bdr_r == '0;
  endproperty
  a_bits_clear: assert property (p_bits_clear) else $error("stale bits while sampling");

  property p_decide_open;
    st_r == amcs_pkg::AMCS_ST_DECIDE |-> !sample_o && weight_upper_o[idx_r];
  endproperty
  a_decide_open: assert property (p_decide_open) else $error("weight under test not upper");

  // Closing a conversion; done must only follow a full latch step
  property p_latch_clear;
    st_r == amcs_pkg::AMCS_ST_LATCH && !start_rise |=> sample_o && weight_upper_o == '0 && done_o;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("no return to sampling after latch");

  property p_idle_track;
    st_r == amcs_pkg::AMCS_ST_IDLE |-> sample_o && weight_upper_o == '0;
  endproperty
  a_idle_track: assert property (p_idle_track) else $error("not tracking input when idle");

  property p_done_rise;
    $rose(done_o) |-> $past(st_r) == amcs_pkg::AMCS_ST_LATCH;
  endproperty
  a_done_rise: assert property (p_done_rise) else $error("done rose outside latch step");

  property p_done_hold;
    done_o && !start_rise |=> done_o;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped without start");

  property p_result_stable;
    !start_rise && st_r != amcs_pkg::AMCS_ST_LATCH |=> $stable(result_o);
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("result changed unasked");

endmodule

// ==== pkg/amcs_cfg.svh ====
// Overview of operation
// - Exactly one of eight analog inputs is routed, chosen by the latched channel code.
// - Channel code is captured on strobe rising edge and held until the next.
// - Start rising edge clears the latched conversion result.
// - Sampling begins at start rising edge and lasts 32 clocks before decisions.
// - A start within 64 clocks aborts the conversion, discards it, restarts.
// - Done output changes within 8 clocks plus 2 microseconds after start.
// - First decision tests weight 128 alone on upper reference.
// - Trip sets the bit and drops the weight; otherwise weight stays upper.
// - Remaining weights are tested one per step in descending order.
// - All 8 bits decided, then the result is latched and the sequencer idles until the next start.
// - Result is straight binary, zero gives 00000000, full scale 11111111.
`ifndef AMCS_CFG_SVH
`define AMCS_CFG_SVH

// Converter geometry
`define AMCS_NUM_CH 8
`define AMCS_NUM_BITS 8
`define AMCS_SAMPLE_CLKS 32
`define AMCS_RESTART_CLKS 64

// Reset values
`define AMCS_RESULT_RST 8'h00
`define AMCS_CHSEL_RST 8'h01

// Done timing: fixed clocks plus a time in microseconds
`define AMCS_CLK_MHZ 125
`define AMCS_EOC_FIX_CLKS 8
`define AMCS_EOC_EXTRA_US 2
`define AMCS_EOC_MAX_CLKS (`AMCS_EOC_FIX_CLKS + `AMCS_EOC_EXTRA_US * `AMCS_CLK_MHZ)

`endif

// ==== pkg/amcs_pkg.sv ====
package amcs_pkg;

  // Sequencer phases
  typedef enum logic [1:0] {
    AMCS_ST_IDLE = 2'b00,
    AMCS_ST_SAMPLE = 2'b01,
    AMCS_ST_DECIDE = 2'b10,
    AMCS_ST_LATCH = 2'b11
  } amcs_state_t;

endpackage

// ==== tb/amcs_far_model.sv ====
`timescale 1ns/1ns
// Host controller and threshold detector on the far side
module amcs_far_model (
  // Clock
  input wire logic core_clk_i,
  // Host controls
  input wire logic ext_start_i,
  input wire logic free_run_i,
  input wire logic done_i,
  // Analog codes per channel and switch state
  input wire logic [63:0] vin_i,
  input wire logic [7:0] chan_sel_i,
  input wire logic sample_i,
  // Into the sequencer
  output logic start_o,
  output logic cmp_trip_o
);
  logic [2:0] idx_r;
  logic tgl_r;
  logic [2:0] ch;
  initial begin
    start_o = 1'b0;
    idx_r = 3'h7;
    tgl_r = 1'b0;
  end
  // Done loops back to start; an outside pulse kicks the loop off
  always @(posedge core_clk_i) begin
    start_o <= ext_start_i | (free_run_i & done_i);
    tgl_r <= ~tgl_r;
    if (sample_i) idx_r <= 3'h7;
    else if (idx_r != 3'h0) idx_r <= idx_r - 3'h1;
  end
  // Toggles while sampling so a stray read is never a lucky match
  always_comb begin
    ch = 3'h0;
    for (int i = 0; i < 8; i++) if (chan_sel_i[i]) ch = i[2:0];
    cmp_trip_o = sample_i ? tgl_r : vin_i[{ch, idx_r}];
  end
endmodule

// ==== tb/adc_mux_conversion_sequencer_tb_top.sv ====
`timescale 1ns/1ns
`include "amcs_cfg.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; $display("BAD %0t mismatch", $time); end end
module adc_mux_conversion_sequencer_tb_top;
  logic core_clk_i, rst_i, addr_latch_i, ext_start, free_run, start_i, cmp_trip_i, sample_o, done_o;
  logic [2:0] chan_addr_i;
  logic [7:0] chan_sel_o, weight_upper_o, result_o, trips, exp_w;
  logic [7:0][7:0] vin;
  logic [31:0] seed;
  logic start_q, done_q;
  logic [7:0] exp_q[$];
  int errors, num_checks, cyc, t0, k, ndone;
  amcs_sequencer u_amcs_sequencer (.core_clk_i(core_clk_i), .rst_i(rst_i), .chan_addr_i(chan_addr_i),
    .addr_latch_i(addr_latch_i), .start_i(start_i), .cmp_trip_i(cmp_trip_i), .chan_sel_o(chan_sel_o),
    .sample_o(sample_o), .weight_upper_o(weight_upper_o), .result_o(result_o), .done_o(done_o));
  amcs_far_model u_amcs_far_model (.core_clk_i(core_clk_i), .ext_start_i(ext_start), .free_run_i(free_run),
    .done_i(done_o), .vin_i(vin), .chan_sel_i(chan_sel_o), .sample_i(sample_o), .start_o(start_i),
    .cmp_trip_o(cmp_trip_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
  endfunction
  // Clock
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic end_sim;
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Bounded wait for a count of done rises
  task automatic wait_n(input int n);
    for (int i = 0; i < 2000 && ndone < n; i++) @(posedge core_clk_i);
    if (ndone < n) begin
      errors++;
      $display("BAD %0t no done", $time);
      end_sim();
    end
  endtask
  // Strobe a code, then scramble the bus to prove it is held
  task automatic latch(input logic [2:0] c);
    @(posedge core_clk_i);
    chan_addr_i <= c;
    addr_latch_i <= 1'b1;
    @(posedge core_clk_i);
    addr_latch_i <= 1'b0;
    chan_addr_i <= ~c;
    @(posedge core_clk_i);
    #1 `CHK(chan_sel_o, 8'h01 << c)
    repeat (3) @(posedge core_clk_i);
    #1 `CHK(chan_sel_o, 8'h01 << c)
  endtask
  // Note taken after the edge, so a level changed on the edge before counts
  task automatic pulse(input logic [2:0] c, input bit note);
    @(posedge core_clk_i);
    ext_start <= 1'b1;
    if (note) exp_q.push_back(vin[c]);
    @(posedge core_clk_i);
    ext_start <= 1'b0;
  endtask
  // Watches outputs against the start edge and the queued results
  always @(posedge core_clk_i) begin
    cyc++;
    if (!rst_i && start_i && !start_q) t0 = cyc;
    if (!rst_i && t0 > 0) begin
      k = cyc - t0;
      if (k == 1) `CHK(result_o, 8'h00)
      if (k >= 2 && k <= 32) `CHK(sample_o, 1'b1)
      if (k >= 33 && k <= 40) begin
        // Weights follow the detector's answers, so a level change mid-run is fine
        exp_w = (~trips & (8'hFF << (41 - k))) | (8'h01 << (40 - k));
        `CHK(weight_upper_o, exp_w)
        `CHK(sample_o, 1'b0)
        `CHK(done_o, 1'b0)
        trips[40 - k] = cmp_trip_i;
      end
      if (done_o && !done_q) begin
        `CHK(k > 40 && k <= `AMCS_EOC_MAX_CLKS, 1'b1)
        `CHK(exp_q.size() != 0, 1'b1)
        if (exp_q.size() != 0) `CHK(result_o, exp_q.pop_front())
        ndone++;
      end
    end
    start_q = start_i;
    done_q = done_o;
  end
  initial begin
    rst_i = 1'b1;
    addr_latch_i = 1'b0;
    chan_addr_i = 3'h0;
    ext_start = 1'b0;
    free_run = 1'b0;
    seed = 32'h893d;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      vin[i] = seed[7:0];
    end
    vin[0] = 8'h00;
    vin[1] = 8'hFF;
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    #1 `CHK({chan_sel_o, sample_o, result_o, done_o}, {8'h01, 1'b1, 8'h00, 1'b0})
    // Every channel, zero and full scale among them
    for (int c = 0; c < 8; c++) begin
      latch(c[2:0]);
      pulse(c[2:0], 1'b1);
      wait_n(ndone + 1);
    end
    // Restart in mid decision: partial result must vanish
    latch(3'h5);
    pulse(3'h5, 1'b0);
    repeat (36) @(posedge core_clk_i);
    // New level differs in bits already decided, so leftover bits would show
    vin[5] <= ~vin[5];
    pulse(3'h5, 1'b1);
    wait_n(ndone + 1);
    // Free-running loop, three conversions from one pulse
    latch(3'h6);
    repeat (3) exp_q.push_back(vin[6]);
    free_run <= 1'b1;
    pulse(3'h6, 1'b0);
    wait_n(ndone + 2);
    free_run <= 1'b0;
    wait_n(ndone + 1);
    repeat (50) @(posedge core_clk_i);
    `CHK(exp_q.size(), 0)
    end_sim();
  end
endmodule
